// File: design/bhs_brake_seq.sv
// Purpose: Motor holding brake sequencer with Wishbone register access
// Assumes: All drive inputs are synchronous to clk
// Notes:   Brake and permission outputs are registered; in sequencing mode permission rises after the opening delay, or at once if servo on drops during it
//
// Functional notes
// [R1] Brake-hold output is high while the brake holds the shaft.
// [R2] Brake-hold output is low while the brake lets the shaft turn.
// [R3] With a brake port, supply is on to release and off to engage.
// [R4] Without a brake port, relay drive is off engaged and on released.
// [R5] Two digital outputs take functions 1 to 14; defaults fault and overload.
// [R6] Configuration 0 means no brake and no sequencing; reset default.
// [R7] Configuration 2 keeps the brake released whatever the servo state.
// [R8] Configuration 1 releases on control bit 0 rising, engages at servo off.
// [R9] Opening delay 0 to 10000 ms allowed for the brake to release.
// [R10] Closing delay 0 to 10000 ms allowed for the brake to engage.
// [R11] Standstill when speed is below a threshold, 0 to 210000 rpm, default 20.
// [R12] Standstill wait bounded by a watch time 0 to 300 s, default 300.
// [R13] Pulse inhibit delay 0 to 299 s, default 0.
// [R14] Closing delay starts when the shorter of watch and inhibit expires.
// [R15] Absolute encoder sets the brake mode itself; incremental uses the setting.
// [R16] Brake engages in the same cycle that motor power is removed; the registered brake-hold output here rises one clock later.
// [R17] From reset until release is due, the brake-hold output stays high.
// [R18] Run permission waits for the opening delay after release; here it rises at once if control bit 0 falls during that delay.
//
// The address map and the Wishbone slave port are this design's own decisions.
`include "bhs_params.svh"
`default_nettype none
module bhs_brake_seq #(
  parameter int unsigned CYCLES_PER_MS = `BHS_CYCLES_PER_MS
) (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        reset_n,
  // Wishbone classic slave
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [31:0] wb_dat_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic        wb_we_i,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  // Drive state
  input  wire logic [15:0] drive_control_word_1,
  input  wire logic [17:0] motor_speed_rpm,
  input  wire logic        motor_power_lost,
  input  wire logic        encoder_absolute,
  input  wire logic        motor_brake_fitted,
  input  wire logic        brake_port_fitted,
  input  wire logic [13:0] drive_status_functions,
  // Brake and outputs
  output logic             brake_hold_output,
  output logic             brake_supply_on,
  output logic             brake_relay_on,
  output logic             run_permit,
  output logic             dout1,
  output logic             dout2
);

  // ****************************************
  // Registers
  // ****************************************
  logic [1:0]  brake_config_select;
  logic [13:0] brake_open_delay;
  logic [13:0] brake_close_delay;
  logic [17:0] standstill_speed_threshold;
  logic [8:0]  standstill_watch_time;
  logic [8:0]  pulse_inhibit_delay;
  logic [3:0]  dout1_function_assign;
  logic [3:0]  dout2_function_assign;

  bhs_pkg::bhs_state_t state;
  bhs_pkg::bhs_state_t next_state;
  logic [13:0] ms_elapsed;
  logic [8:0]  s_elapsed;
  logic        cw_bit0_q;
  logic        standstill;

  bhs_tick_if tk ();

  bhs_tick_gen #(
    .CYCLES_PER_MS (CYCLES_PER_MS)
  ) i_bhs_tick_gen (
    .clk     (clk),
    .reset_n (reset_n),
    .tk      (tk)
  );

  // ****************************************
  // Bus decode
  // ****************************************
  wire        bus_req   = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  wire        bus_wr    = bus_req & wb_we_i;
  wire        hit_cfg   = (wb_adr_i == `BHS_OFF_CFG);
  wire        hit_open  = (wb_adr_i == `BHS_OFF_OPEN);
  wire        hit_close = (wb_adr_i == `BHS_OFF_CLOSE);
  wire        hit_thr   = (wb_adr_i == `BHS_OFF_THRESH);
  wire        hit_watch = (wb_adr_i == `BHS_OFF_WATCH);
  wire        hit_inhib = (wb_adr_i == `BHS_OFF_INHIB);
  wire        hit_dout  = (wb_adr_i == `BHS_OFF_DOUT);
  wire        hit_stat  = (wb_adr_i == `BHS_OFF_STATUS);
  wire [31:0] lane_mask = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}}, {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};

  // ****************************************
  // Read view and byte-lane merge
  // ****************************************
  wire [31:0] rd_cfg   = {30'h0, brake_config_select};
  wire [31:0] rd_open  = {18'h0, brake_open_delay};
  wire [31:0] rd_close = {18'h0, brake_close_delay};
  wire [31:0] rd_thr   = {14'h0, standstill_speed_threshold};
  wire [31:0] rd_watch = {23'h0, standstill_watch_time};
  wire [31:0] rd_inhib = {23'h0, pulse_inhibit_delay};
  wire [31:0] rd_dout  = {20'h0, dout2_function_assign, 4'h0, dout1_function_assign};
  wire [1:0]  eff_cfg;
  wire [31:0] rd_stat;
  assign rd_stat[2:0] = state;
  assign rd_stat[3] = 1'b0;
  assign rd_stat[`BHS_ST_HOLD] = brake_hold_output;
  assign rd_stat[`BHS_ST_PERMIT] = run_permit;
  assign rd_stat[`BHS_ST_STILL] = standstill;
  assign rd_stat[7] = 1'b0;
  assign rd_stat[`BHS_ST_MODE_LSB +: 2] = eff_cfg;
  assign rd_stat[31:10] = 22'h0;

  wire [31:0] rd_mux = hit_cfg   ? rd_cfg   :
                       hit_open  ? rd_open  :
                       hit_close ? rd_close :
                       hit_thr   ? rd_thr   :
                       hit_watch ? rd_watch :
                       hit_inhib ? rd_inhib :
                       hit_dout  ? rd_dout  :
                       hit_stat  ? rd_stat  : 32'h0;

  wire [31:0] wm_cfg   = (rd_cfg   & ~lane_mask) | (wb_dat_i & lane_mask);
  wire [31:0] wm_open  = (rd_open  & ~lane_mask) | (wb_dat_i & lane_mask);
  wire [31:0] wm_close = (rd_close & ~lane_mask) | (wb_dat_i & lane_mask);
  wire [31:0] wm_thr   = (rd_thr   & ~lane_mask) | (wb_dat_i & lane_mask);
  wire [31:0] wm_watch = (rd_watch & ~lane_mask) | (wb_dat_i & lane_mask);
  wire [31:0] wm_inhib = (rd_inhib & ~lane_mask) | (wb_dat_i & lane_mask);
  wire [31:0] wm_dout  = (rd_dout  & ~lane_mask) | (wb_dat_i & lane_mask);

  // ****************************************
  // Clamped next values
  // ****************************************
  // Out-of-range delays, threshold and times saturate; configuration code 3 in bits 1:0 keeps the current value and bits above 1 are ignored
  wire [1:0]  wv_cfg   = (wm_cfg[1:0] > `BHS_CFG_OPEN) ? brake_config_select : wm_cfg[1:0]; // see [R6]
  wire [13:0] wv_open  = (wm_open[31:14] != 18'h0 || wm_open[13:0] > `BHS_MAX_DELAY_MS) ?
                         `BHS_MAX_DELAY_MS : wm_open[13:0]; // see [R9]
  wire [13:0] wv_close = (wm_close[31:14] != 18'h0 || wm_close[13:0] > `BHS_MAX_DELAY_MS) ?
                         `BHS_MAX_DELAY_MS : wm_close[13:0]; // see [R10]
  wire [17:0] wv_thr   = (wm_thr[31:18] != 14'h0 || wm_thr[17:0] > `BHS_MAX_THRESH) ?
                         `BHS_MAX_THRESH : wm_thr[17:0]; // see [R11]
  wire [8:0]  wv_watch = (wm_watch[31:9] != 23'h0 || wm_watch[8:0] > `BHS_MAX_WATCH) ?
                         `BHS_MAX_WATCH : wm_watch[8:0]; // see [R12]
  wire [8:0]  wv_inhib = (wm_inhib[31:9] != 23'h0 || wm_inhib[8:0] > `BHS_MAX_INHIB) ?
                         `BHS_MAX_INHIB : wm_inhib[8:0]; // see [R13]
  wire [3:0]  wd1      = wm_dout[3:0];
  wire [3:0]  wd2      = wm_dout[`BHS_DOUT2_LSB +: 4];
  wire        wd1_ok   = (wd1 >= `BHS_FN_MIN) && (wd1 <= `BHS_FN_MAX);
  wire        wd2_ok   = (wd2 >= `BHS_FN_MIN) && (wd2 <= `BHS_FN_MAX);

  // ****************************************
  // Bus slave
  // ****************************************
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0;
    end else begin
      wb_ack_o <= bus_req;
      wb_dat_o <= bus_req ? rd_mux : 32'h0;
    end
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      brake_config_select        <= `BHS_CFG_NONE; // see [R6]
      brake_open_delay           <= `BHS_RST_OPEN_MS;
      brake_close_delay          <= `BHS_RST_CLOSE_MS;
      standstill_speed_threshold <= `BHS_RST_THRESH;
      standstill_watch_time      <= `BHS_RST_WATCH;
      pulse_inhibit_delay        <= `BHS_RST_INHIB;
      dout1_function_assign      <= `BHS_RST_DOUT1; // see [R5]
      dout2_function_assign      <= `BHS_RST_DOUT2; // see [R5]
    end else if (bus_wr) begin
      if (hit_cfg)   brake_config_select        <= wv_cfg;
      if (hit_open)  brake_open_delay           <= wv_open;
      if (hit_close) brake_close_delay          <= wv_close;
      if (hit_thr)   standstill_speed_threshold <= wv_thr;
      if (hit_watch) standstill_watch_time      <= wv_watch;
      if (hit_inhib) pulse_inhibit_delay        <= wv_inhib;
      if (hit_dout && wd1_ok) dout1_function_assign <= wd1; // see [R5]
      if (hit_dout && wd2_ok) dout2_function_assign <= wd2; // see [R5]
    end
  end

  // ****************************************
  // Mode and sequence conditions
  // ****************************************
  // Absolute encoders report whether the motor carries a brake
  assign eff_cfg = encoder_absolute ? (motor_brake_fitted ? `BHS_CFG_SEQ : `BHS_CFG_NONE)
                                    : brake_config_select; // see [R15]

  wire seq_mode   = (eff_cfg == `BHS_CFG_SEQ);
  wire servo_req  = drive_control_word_1[0];
  wire servo_rise = servo_req & ~cw_bit0_q; // see [R8]
  wire still_now  = motor_speed_rpm < standstill_speed_threshold; // see [R11]
  wire watch_done = s_elapsed >= standstill_watch_time; // see [R12]
  wire inhib_done = s_elapsed >= pulse_inhibit_delay; // see [R13]
  // Standstill or either timer ending first starts the closing delay
  wire stop_done  = standstill | watch_done | inhib_done; // see [R14]
  wire open_done  = ms_elapsed >= brake_open_delay; // see [R9]
  wire close_done = ms_elapsed >= brake_close_delay; // see [R10]

  // ****************************************
  // Next state
  // ****************************************
  always_comb begin
    next_state = state;
    if (!seq_mode || motor_power_lost) begin
      next_state = bhs_pkg::ST_HELD; // see [R16]
    end else begin
      unique case (state)
        bhs_pkg::ST_HELD: begin
          if (servo_rise) next_state = bhs_pkg::ST_OPENING; // see [R8]
        end
        bhs_pkg::ST_OPENING: begin
          if (!servo_req) next_state = bhs_pkg::ST_STOPPING;
          else if (open_done) next_state = bhs_pkg::ST_RUN; // see [R18]
        end
        bhs_pkg::ST_RUN: begin
          if (!servo_req) next_state = bhs_pkg::ST_STOPPING;
        end
        bhs_pkg::ST_STOPPING: begin
          if (stop_done) next_state = bhs_pkg::ST_CLOSING; // see [R14]
        end
        bhs_pkg::ST_CLOSING: begin
          if (close_done) next_state = bhs_pkg::ST_HELD; // see [R10]
        end
        // Codes 5 to 7 are unreachable; should one appear, hold the brake
        default: next_state = bhs_pkg::ST_HELD;
      endcase
    end
  end

  // A state change realigns ticks and clears elapsed time
  assign tk.restart = (next_state != state);

  // ****************************************
  // Output decisions
  // ****************************************
  // Brake held in idle and while closing; released while opening, running, stopping
  wire seq_release = (next_state == bhs_pkg::ST_OPENING) ||
                     (next_state == bhs_pkg::ST_RUN) ||
                     (next_state == bhs_pkg::ST_STOPPING);
  // Power stays on through the closing delay so the load is held until the brake bites
  wire seq_permit  = (next_state == bhs_pkg::ST_RUN) ||
                     (next_state == bhs_pkg::ST_STOPPING) ||
                     (next_state == bhs_pkg::ST_CLOSING);
  wire next_release = motor_power_lost ? 1'b0 :
                      (eff_cfg == `BHS_CFG_OPEN) ? 1'b1 : // see [R7]
                      seq_mode ? seq_release : 1'b0; // see [R6]
  wire next_permit  = motor_power_lost ? 1'b0 :
                      seq_mode ? seq_permit : servo_req;

  // ****************************************
  // Output functions
  // ****************************************

  // Function n sits at bit n-1; the brake-hold function replaces its input bit
  logic [13:0] fn_vec;
  logic [1:0]  dout_q;
  wire  [3:0]  fn_sel [2];
  assign fn_sel[0] = dout1_function_assign - `BHS_FN_MIN;
  assign fn_sel[1] = dout2_function_assign - `BHS_FN_MIN;

  genvar gi;
  generate
    for (gi = 0; gi < 14; gi++) begin : g_fn
      if (gi + 1 == `BHS_FN_BRAKE) begin : g_brake
        assign fn_vec[gi] = brake_hold_output; // see [R5]
      end else begin : g_other
        assign fn_vec[gi] = drive_status_functions[gi];
      end
    end
    for (gi = 0; gi < 2; gi++) begin : g_dout
      always_ff @(posedge clk) begin
        if (!reset_n) dout_q[gi] <= 1'b0;
        else dout_q[gi] <= fn_vec[fn_sel[gi]]; // see [R5]
      end
    end
  endgenerate

  assign dout1 = dout_q[0];
  assign dout2 = dout_q[1];

  // ****************************************
  // Sequencer state
  // ****************************************
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      state      <= bhs_pkg::ST_HELD;
      cw_bit0_q  <= 1'b0;
      standstill <= 1'b0;
    end else begin
      state      <= next_state;
      cw_bit0_q  <= servo_req;
      standstill <= still_now; // see [R11]
    end
  end

  // ****************************************
  // Delay timers
  // ****************************************

  always_ff @(posedge clk) begin
    if (!reset_n || tk.restart) begin
      ms_elapsed <= 14'h0000;
      s_elapsed  <= 9'h000;
    end else begin
      if (tk.ms_tick && ms_elapsed != 14'h3FFF) ms_elapsed <= ms_elapsed + 14'h0001;
      if (tk.s_tick && s_elapsed != 9'h1FF) s_elapsed <= s_elapsed + 9'h001;
    end
  end

  // ****************************************
  // Brake drive
  // ****************************************
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      brake_hold_output <= 1'b1; // see [R17]
      brake_supply_on   <= 1'b0;
      brake_relay_on    <= 1'b0;
      run_permit        <= 1'b0;
    end else begin
      brake_hold_output <= ~next_release; // see [R1] see [R2] see [R16]
      brake_supply_on   <= next_release & brake_port_fitted; // see [R3]
      brake_relay_on    <= next_release & ~brake_port_fitted; // see [R4]
      run_permit        <= next_permit; // see [R18] see [R16]
    end
  end

endmodule : bhs_brake_seq
`default_nettype wire

// File: design/bhs_params.svh
// Purpose: Offsets, field positions, reset values and timing counts of the brake sequencer
// Assumes: Included by bare name from design files
// Notes:   Definitions only
`ifndef BHS_PARAMS_SVH
`define BHS_PARAMS_SVH

// ****************************************
// Register byte offsets
// ****************************************
`define BHS_OFF_CFG     8'h00
`define BHS_OFF_OPEN    8'h04
`define BHS_OFF_CLOSE   8'h08
`define BHS_OFF_THRESH  8'h0C
`define BHS_OFF_WATCH   8'h10
`define BHS_OFF_INHIB   8'h14
`define BHS_OFF_DOUT    8'h18
`define BHS_OFF_STATUS  8'h1C

// ****************************************
// Field positions
// ****************************************
`define BHS_DOUT2_LSB   8
`define BHS_ST_HOLD     4
`define BHS_ST_PERMIT   5
`define BHS_ST_STILL    6
`define BHS_ST_MODE_LSB 8

// ****************************************
// Configuration codes
// ****************************************
`define BHS_CFG_NONE    2'h0
`define BHS_CFG_SEQ     2'h1
`define BHS_CFG_OPEN    2'h2

// ****************************************
// Reset values and limits
// ****************************************
`define BHS_RST_OPEN_MS  14'h0064
`define BHS_RST_CLOSE_MS 14'h0064
`define BHS_RST_THRESH   18'h00014
`define BHS_RST_WATCH    9'h12C
`define BHS_RST_INHIB    9'h000
`define BHS_RST_DOUT1    4'h2
`define BHS_RST_DOUT2    4'h9
`define BHS_MAX_DELAY_MS 14'h2710
`define BHS_MAX_THRESH   18'h33450
`define BHS_MAX_WATCH    9'h12C
`define BHS_MAX_INHIB    9'h12B
`define BHS_FN_MIN       4'h1
`define BHS_FN_MAX       4'hE
`define BHS_FN_BRAKE     4'hB

// ****************************************
// Timing
// ****************************************
`define BHS_CLK_HZ        125000000
`define BHS_TICK_MS       1
`define BHS_CYCLES_PER_MS (`BHS_CLK_HZ / 1000 * `BHS_TICK_MS)
`define BHS_MS_PER_S      1000

`endif

// File: design/bhs_pkg.sv
// Purpose: Types shared by the brake sequencer
// Assumes: Nothing
// Notes:   Constants live in bhs_params.svh
`default_nettype none
package bhs_pkg;
  typedef enum logic [2:0] {
    ST_HELD,
    ST_OPENING,
    ST_RUN,
    ST_STOPPING,
    ST_CLOSING
  } bhs_state_t;
endpackage : bhs_pkg
`default_nettype wire

// File: design/bhs_tick_gen.sv
// Purpose: Prescaler giving millisecond and second ticks
// Assumes: clk at the rate set by CYCLES_PER_MS
// Notes:   Restart clears the phase so a delay counts whole periods
`include "bhs_params.svh"
`default_nettype none
module bhs_tick_gen #(
  parameter int unsigned CYCLES_PER_MS = `BHS_CYCLES_PER_MS
) (
  // Clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // Ticks
  bhs_tick_if.gen  tk
);
  logic [31:0] cyc_cnt;
  logic [9:0]  ms_cnt;
  wire         cyc_end = (cyc_cnt == CYCLES_PER_MS - 1);
  wire         ms_end  = (ms_cnt == 10'(`BHS_MS_PER_S - 1));

  always_ff @(posedge clk) begin
    if (!reset_n || tk.restart) begin
      cyc_cnt    <= 32'h0;
      ms_cnt     <= 10'h000;
      tk.ms_tick <= 1'b0;
      tk.s_tick  <= 1'b0;
    end else begin
      cyc_cnt    <= cyc_end ? 32'h0 : cyc_cnt + 32'h1;
      ms_cnt     <= !cyc_end ? ms_cnt : (ms_end ? 10'h000 : ms_cnt + 10'h001);
      tk.ms_tick <= cyc_end;
      tk.s_tick  <= cyc_end && ms_end;
    end
  end
endmodule : bhs_tick_gen
`default_nettype wire

// File: design/bhs_tick_if.sv
// Purpose: Millisecond and second ticks between prescaler and sequencer
// Assumes: Single clock domain
// Notes:   restart realigns the tick phase
`default_nettype none
interface bhs_tick_if;
  logic restart;
  logic ms_tick;
  logic s_tick;
  modport gen  (input restart, output ms_tick, output s_tick);
  modport user (output restart, input ms_tick, input s_tick);
endinterface : bhs_tick_if
`default_nettype wire

// File: testbench/bhs_brake_seq_assertions.sv
// Purpose: Port assertions for the brake sequencer
// Assumes: Bound to every bhs_brake_seq
// Notes:   The brake port variant input must not change while released
`default_nettype none
module bhs_brake_seq_assertions (
  // Clock and reset
  input wire logic        clk,
  input wire logic        reset_n,
  // Bus
  input wire logic        wb_cyc_i,
  input wire logic        wb_stb_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic        wb_ack_o,
  // Brake
  input wire logic        motor_power_lost,
  input wire logic        brake_hold_output,
  input wire logic        brake_supply_on,
  input wire logic        brake_relay_on,
  input wire logic        run_permit
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!reset_n);
  a_ack_single: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack held two cycles");
  a_ack_cause: assert property (wb_ack_o |-> $past(wb_cyc_i && wb_stb_i))
    else $error("ack without request");
  a_req_answer: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("request not answered");
  a_idle_data: assert property (!wb_ack_o |-> wb_dat_o == 32'h0)
    else $error("read data outside ack");
  a_reset_hold: assert property ($rose(reset_n) |-> brake_hold_output && !run_permit)
    else $error("brake open out of reset");
  a_engaged_dead: assert property (brake_hold_output |-> !brake_supply_on && !brake_relay_on)
    else $error("brake drive on while engaged");
  a_released_live: assert property (!brake_hold_output |-> brake_supply_on ^ brake_relay_on)
    else $error("brake drive wrong while released");
  a_power_cut: assert property (motor_power_lost |=> brake_hold_output && !run_permit)
    else $error("brake open after power loss");
  a_open_first: assert property ($fell(brake_hold_output) |-> !run_permit)
    else $error("run permitted before opening delay");
endmodule : bhs_brake_seq_assertions
bind bhs_brake_seq bhs_brake_seq_assertions i_bhs_brake_seq_assertions (.clk, .reset_n, .wb_cyc_i, .wb_stb_i,
  .wb_dat_o, .wb_ack_o, .motor_power_lost, .brake_hold_output, .brake_supply_on, .brake_relay_on, .run_permit);
`default_nettype wire

// File: testbench/bhs_motor_model.sv
// Purpose: Motor and load behind the brake sequencer
// Assumes: One clock; speed in rpm
// Notes:   A stuck load keeps turning after the drive lets go
`default_nettype none
module bhs_motor_model (
  // Clock
  input wire logic        clk,
  // Drive side
  input wire logic        run_permit,
  input wire logic        brake_hold_output,
  input wire logic        servo_on,
  input wire logic        stuck,
  input wire logic [17:0] step,
  // Speed
  output var logic [17:0] motor_speed_rpm
);
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [17:0] TOP = 18'h003E8;
  initial motor_speed_rpm = 18'h00000;
  // Torque only while servo on is asked, permitted and the brake is open
  always @(posedge clk) begin
    if (run_permit && servo_on && !brake_hold_output) begin
      motor_speed_rpm <= (motor_speed_rpm + step > TOP) ? TOP : motor_speed_rpm + step;
    end else if (!stuck) begin
      motor_speed_rpm <= (motor_speed_rpm > step) ? motor_speed_rpm - step : 18'h00000;
    end
  end
endmodule : bhs_motor_model
`default_nettype wire

// File: testbench/test_bhs_brake_seq.sv
// Purpose: Self-checking bench for the brake sequencer
// Assumes: CYCLES_PER_MS cut to 10, so one second is 10000 cycles
// Notes:   Bus reads are scored from a queue by a separate monitor
`default_nettype none
module test_bhs_brake_seq;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int CPM = 10;
  logic        clk = 1'b0, reset_n = 1'b0;
  logic [7:0]  wb_adr_i = 8'h00;
  logic [31:0] wb_dat_i = 32'h0, wb_dat_o, v;
  logic [3:0]  wb_sel_i = 4'hF;
  logic        wb_we_i = 1'b0, wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_ack_o;
  logic [15:0] drive_control_word_1 = 16'h0;
  logic        motor_power_lost = 1'b0, encoder_absolute = 1'b0, motor_brake_fitted = 1'b0;
  logic        brake_port_fitted = 1'b0, stuck = 1'b0, chk_dout = 1'b0;
  logic [17:0] step = 18'h00032, motor_speed_rpm;
  logic [13:0] drive_status_functions = 14'h0, fns_d = 14'h0;
  logic [3:0]  fn1 = 4'h5, fn2 = 4'hE;
  logic        brake_hold_output, brake_supply_on, brake_relay_on, run_permit, dout1, dout2;
  logic [31:0] exp_q[$];
  logic [31:0] rst_v[8] = '{32'h0, 32'h64, 32'h64, 32'h14, 32'h12C, 32'h0, 32'h902, 32'h50};
  logic [31:0] tv[9][3] = '{'{32'h04, 32'h3000, 32'h2710}, '{32'h0C, 32'h3FFFF, 32'h33450},
    '{32'h10, 32'h1FF, 32'h12C}, '{32'h14, 32'h1FF, 32'h12B}, '{32'h00, 32'h3, 32'h0},
    '{32'h18, 32'hF00, 32'h902}, '{32'h18, 32'hE05, 32'hE05}, '{32'h1C, 32'hFFFF, 32'h50},
    '{32'h20, 32'h1, 32'h0}};
  int          num_errors = 0, compares = 0, seed = 52, k;
  always #4 clk = ~clk;
  bhs_brake_seq #(.CYCLES_PER_MS(CPM)) i_bhs_brake_seq (.clk, .reset_n, .wb_adr_i, .wb_dat_i, .wb_sel_i,
    .wb_we_i, .wb_cyc_i, .wb_stb_i, .wb_dat_o, .wb_ack_o, .drive_control_word_1, .motor_speed_rpm,
    .motor_power_lost, .encoder_absolute, .motor_brake_fitted, .brake_port_fitted, .drive_status_functions,
    .brake_hold_output, .brake_supply_on, .brake_relay_on, .run_permit, .dout1, .dout2);
  bhs_motor_model i_bhs_motor_model (.clk, .run_permit, .brake_hold_output, .servo_on (drive_control_word_1[0]),
    .stuck, .step, .motor_speed_rpm);
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      num_errors++;
      $display("Error %s expected %0h seen %0h", what, exp, seen);
    end
  endtask : check
  task automatic test_done;
    $display("compares %0d num_errors %0d", compares, num_errors);
    if (num_errors == 0 && compares > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : test_done
  // Classic cycle: hold everything until ack is sampled, then idle one cycle
  task automatic bus(input logic [7:0] a, input logic w, input logic [31:0] d);
    int n = 0;
    wb_adr_i <= a;
    wb_we_i <= w;
    wb_dat_i <= d;
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    do begin
      @(posedge clk);
      n++;
    end while (wb_ack_o !== 1'b1 && n < 20);
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    wb_we_i <= 1'b0;
    if (wb_ack_o !== 1'b1) begin
      num_errors++;
      test_done();
    end
    @(posedge clk);
  endtask : bus
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    exp_q.push_back(e);
    bus(a, 1'b0, 32'h0);
  endtask : rd
  // Counts edges until the chosen output takes the value
  task automatic wait_on(input logic p, input logic val, input int lim);
    k = 0;
    do begin
      @(posedge clk);
      k++;
    end while ((p ? run_permit : brake_hold_output) !== val && k < lim);
    if (k >= lim) begin
      num_errors++;
      test_done();
    end
  endtask : wait_on
  task automatic open_run;
    drive_control_word_1 <= 16'h0001;
    wait_on(1'b0, 1'b0, 10);
    check("release edge", k, 2);
    check("drive", {brake_supply_on, brake_relay_on}, 2'b10);
    wait_on(1'b1, 1'b1, 100);
    check("open delay", k, 2 * CPM + 2);
    repeat (30) @(posedge clk);
  endtask : open_run
  always @(posedge clk) drive_status_functions <= 14'($random(seed));
  always @(posedge clk) begin
    fns_d <= drive_status_functions;
    if (wb_ack_o === 1'b1 && wb_we_i === 1'b0) begin
      check("read data", wb_dat_o, exp_q.pop_front());
    end
    if (chk_dout === 1'b1) begin
      check("dout1", dout1, fns_d[fn1 - 4'h1]);
      check("dout2", dout2, fns_d[fn2 - 4'h1]);
    end
  end
  initial begin
    repeat (4) @(posedge clk);
    reset_n <= 1'b1;
    @(posedge clk);
    check("hold at reset", brake_hold_output, 1'b1);
    foreach (rst_v[i]) rd(8'(4 * i), rst_v[i]);
    for (int i = 0; i < 9; i++) begin
      bus(tv[i][0][7:0], 1'b1, tv[i][1]);
      rd(tv[i][0][7:0], tv[i][2]);
    end
    v = 32'($unsigned($random(seed)) % 10001);
    bus(8'h08, 1'b1, v);
    rd(8'h08, v);
    chk_dout <= 1'b1;
    repeat (20) @(posedge clk);
    chk_dout <= 1'b0;
    $display("test registers done");
    drive_control_word_1 <= 16'h0001;
    repeat (3) @(posedge clk);
    check("no brake", {brake_hold_output, run_permit}, 2'b11);
    drive_control_word_1 <= 16'h0000;
    bus(8'h00, 1'b1, 32'h2);
    repeat (2) @(posedge clk);
    check("always open", {brake_hold_output, brake_relay_on, brake_supply_on}, 3'b010);
    drive_control_word_1 <= 16'h0001;
    repeat (3) @(posedge clk);
    check("open running", {brake_hold_output, run_permit}, 2'b01);
    drive_control_word_1 <= 16'h0000;
    bus(8'h00, 1'b1, 32'h1);
    brake_port_fitted <= 1'b1;
    bus(8'h04, 1'b1, 32'h2);
    bus(8'h08, 1'b1, 32'h3);
    bus(8'h0C, 1'b1, 32'h14);
    bus(8'h10, 1'b1, 32'h1);
    bus(8'h14, 1'b1, 32'h1);
    $display("test modes done");
    open_run();
    drive_control_word_1 <= 16'h0000;
    wait_on(1'b0, 1'b1, 200);
    check("standstill wait", k > 15, 1'b1);
    check("permit at close", run_permit, 1'b1);
    wait_on(1'b1, 1'b0, 100);
    check("close delay", k, 3 * CPM + 2);
    stuck <= 1'b1;
    bus(8'h14, 1'b1, 32'h2);
    open_run();
    drive_control_word_1 <= 16'h0000;
    wait_on(1'b0, 1'b1, 10100);
    check("watch expiry", k > 9998 && k < 10005, 1'b1);
    wait_on(1'b1, 1'b0, 100);
    bus(8'h14, 1'b1, 32'h0);
    open_run();
    drive_control_word_1 <= 16'h0000;
    wait_on(1'b0, 1'b1, 10);
    check("inhibit zero", k <= 4, 1'b1);
    wait_on(1'b1, 1'b0, 100);
    stuck <= 1'b0;
    open_run();
    motor_power_lost <= 1'b1;
    wait_on(1'b0, 1'b1, 10);
    check("power cut", {k[3:0], run_permit}, {4'h2, 1'b0});
    motor_power_lost <= 1'b0;
    repeat (5) @(posedge clk);
    check("needs new edge", brake_hold_output, 1'b1);
    drive_control_word_1 <= 16'h0000;
    encoder_absolute <= 1'b1;
    repeat (30) @(posedge clk);
    rd(8'h1C, 32'h50);
    motor_brake_fitted <= 1'b1;
    repeat (3) @(posedge clk);
    rd(8'h1C, 32'h150);
    $display("test sequencing done");
    test_done();
  end
endmodule : test_bhs_brake_seq
`default_nettype wire
